/* hdl/mspb_pkg.sv */
// shared constants for one burst-counting memory port
// assumes every user imports the whole package
package mspb_pkg;

   // array geometry defaults
   localparam int ADDR_W_DEF = 16;
   localparam int DATA_W_DEF = 18;
   localparam int LANE_W     = 9;
   localparam int LANE_N     = 2;

   // byte lane positions in the lane select vector
   localparam int LANE_LOW   = 0;
   localparam int LANE_HIGH  = 1;

   // wrap mask after reset: counter runs over the full space
   localparam logic [ADDR_W_DEF-1:0] MASK_RST = 16'hFFFF;
   localparam logic [ADDR_W_DEF-1:0] CNT_RST  = 16'h0000;

   // reset synchroniser depth
   localparam int RST_SYNC_W = 2;

   // readback pipeline: request, no-operation cycle, drive
   typedef enum logic [2:0] {
      RB_IDLE  = 3'b001,
      RB_WAIT  = 3'b010,
      RB_DRIVE = 3'b100
   } mspb_rb_e;

endpackage

/* hdl/mspb_ctr_if.sv */
// link between the port logic and its burst counter unit
// assumes both ends share one clock and one reset
`timescale 1ns/10ps
interface mspb_ctr_if #(
   parameter int ADDR_W = 16
);
   logic              rst_n;      // synchronised global reset, low active
   logic              sys_rst;    // synchronous local reset
   logic              clear_n;
   logic              mask_load_n;
   logic              load_n;
   logic              step_n;
   logic [ADDR_W-1:0] addr_in;
   logic [ADDR_W-1:0] count;
   logic [ADDR_W-1:0] mask;
   logic              wrap_n;

   modport ctl (
      output rst_n, sys_rst, clear_n, mask_load_n, load_n, step_n, addr_in,
      input  count, mask, wrap_n
   );
   modport unit (
      input  rst_n, sys_rst, clear_n, mask_load_n, load_n, step_n, addr_in,
      output count, mask, wrap_n
   );
endinterface

/* hdl/mspb_burst_counter.sv */
// burst address counter with wrap mask and one-cycle wrap flag
// assumes controls are already in the clock domain, low active except sys_rst
`timescale 1ns/10ps
module mspb_burst_counter
   import mspb_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
) (
   input  wire logic i_clock,
   mspb_ctr_if.unit  ctr
);

   logic [ADDR_W-1:0] cnt_q;
   logic [ADDR_W-1:0] cnt_d;
   logic [ADDR_W-1:0] mask_q;
   logic [ADDR_W-1:0] mask_d;
   logic              wrap_q;
   logic              wrap_d;

   // one action per cycle, highest priority first
   always_comb begin
      logic [ADDR_W-1:0] inc;
      inc    = cnt_q + ADDR_W'(1);
      cnt_d  = cnt_q;
      mask_d = mask_q;
      wrap_d = 1'b1;
      if (ctr.sys_rst) begin
         cnt_d  = ADDR_W'(CNT_RST);
         mask_d = ADDR_W'(MASK_RST);
      end else if (!ctr.clear_n) begin
         cnt_d = '0;
      end else if (!ctr.mask_load_n) begin
         mask_d = ctr.addr_in;
      end else if (!ctr.load_n) begin
         cnt_d = ctr.addr_in;
      end else if (!ctr.step_n) begin
         // bits outside the mask hold, so bursts stay in their partition
         cnt_d = (cnt_q & ~mask_q) | (inc & mask_q);
         if ((inc & mask_q) == '0) begin
            wrap_d = 1'b0;
         end
      end
   end

   // global reset acts at once, no clock needed
   always_ff @(posedge i_clock or negedge ctr.rst_n) begin
      if (!ctr.rst_n) begin
         cnt_q  <= ADDR_W'(CNT_RST);
         mask_q <= ADDR_W'(MASK_RST);
         wrap_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_d;
         mask_q <= mask_d;
         wrap_q <= wrap_d;
      end
   end

   assign ctr.count  = cnt_q;
   assign ctr.mask   = mask_q;
   assign ctr.wrap_n = wrap_q;

endmodule

/* hdl/mspb_port.sv */
// one synchronous access port of a shared static memory
// assumes host pins are driven on i_clock; two-way pins are split
// into input, output and output enable, resolved outside
`timescale 1ns/10ps
module mspb_port
   import mspb_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int DATA_W = DATA_W_DEF
) (
   input  wire logic              i_clock,
   input  wire logic              i_sys_rst,
   input  wire logic              i_global_reset_n,
   input  wire logic              i_chip_select_active_low,
   input  wire logic              i_chip_select_active_high,
   input  wire logic              i_read_write_n,
   input  wire logic              i_output_enable_n,
   input  wire logic              i_lower_byte_select_n,
   input  wire logic              i_upper_byte_select_n,
   input  wire logic              i_burst_counter_clear_n,
   input  wire logic              i_wrap_mask_load_n,
   input  wire logic              i_burst_counter_load_n,
   input  wire logic              i_burst_counter_step_n,
   input  wire logic              i_counter_readback_n,
   input  wire logic              i_wrap_mask_readback_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   output logic      [ADDR_W-1:0] o_addr,
   output logic                   o_addr_oe,
   input  wire logic [DATA_W-1:0] i_data,
   output logic      [DATA_W-1:0] o_data,
   output logic      [DATA_W-1:0] o_data_oe,
   output logic                   o_counter_wrap_flag_n,
   output logic                   o_port_selected
);

   localparam int DEPTH = 1 << ADDR_W;

   mspb_ctr_if #(.ADDR_W(ADDR_W)) ctr ();

   // ---- global reset: asserts at once, releases on a clock edge
   logic [RST_SYNC_W-1:0] rst_sync_q;
   logic [RST_SYNC_W-1:0] rst_sync_d;

   always_comb begin
      rst_sync_d = {rst_sync_q[RST_SYNC_W-2:0], 1'b1};
   end

   // release is synchronised so no flop sees a runt recovery
   always_ff @(posedge i_clock or negedge i_global_reset_n) begin
      if (!i_global_reset_n) begin
         rst_sync_q <= '0;
      end else begin
         rst_sync_q <= rst_sync_d;
      end
   end

   logic rst_n;
   assign rst_n = rst_sync_q[RST_SYNC_W-1];

   // ---- port selection and access kind
   logic              selected;
   logic [LANE_N-1:0] lane_n;
   logic              rb_req;
   logic              rb_idle;
   logic              do_write;
   logic              do_read;
   logic [ADDR_W-1:0] acc_addr;

   assign selected = !i_chip_select_active_low && i_chip_select_active_high;
   assign lane_n[LANE_LOW]  = i_lower_byte_select_n;
   assign lane_n[LANE_HIGH] = i_upper_byte_select_n;
   assign rb_req   = !i_counter_readback_n || !i_wrap_mask_readback_n;
   // address pins are an output during readback, so no array access then
   assign do_write = selected && !i_read_write_n && rb_idle;
   assign do_read  = selected && i_read_write_n && rb_idle;
   // while stepping the internal counter replaces the address pins
   assign acc_addr = !i_burst_counter_step_n ? ctr.count : i_addr;

   // ---- burst counter unit
   assign ctr.rst_n       = rst_n;
   assign ctr.sys_rst     = i_sys_rst;
   assign ctr.clear_n     = i_burst_counter_clear_n;
   assign ctr.mask_load_n = i_wrap_mask_load_n;
   assign ctr.load_n      = i_burst_counter_load_n;
   assign ctr.step_n      = i_burst_counter_step_n;
   assign ctr.addr_in     = i_addr;

   mspb_burst_counter #(
      .ADDR_W (ADDR_W)
   ) u_counter (
      .i_clock (i_clock),
      .ctr     (ctr.unit)
   );

   assign o_counter_wrap_flag_n = ctr.wrap_n;

   // ---- readback pipeline: request, idle cycle that samples, drive
   mspb_rb_e          rb_state_q;
   mspb_rb_e          rb_state_d;
   logic [ADDR_W-1:0] rb_val_q;
   logic [ADDR_W-1:0] rb_val_d;

   always_comb begin
      rb_state_d = rb_state_q;
      rb_val_d   = rb_val_q;
      unique case (rb_state_q)
         RB_IDLE: begin
            if (rb_req) begin
               rb_state_d = RB_WAIT;
            end
         end
         RB_WAIT: begin
            rb_state_d = rb_req ? RB_DRIVE : RB_IDLE;
         end
         RB_DRIVE: begin
            if (!rb_req) begin
               rb_state_d = RB_IDLE;
            end
         end
         default: begin
            rb_state_d = RB_IDLE;
         end
      endcase
      // value refreshed while driving; counter wins over mask
      if (rb_req && (rb_state_q != RB_IDLE)) begin
         rb_val_d = !i_counter_readback_n ? ctr.count : ctr.mask;
      end
      if (i_sys_rst) begin
         rb_state_d = RB_IDLE;
         rb_val_d   = '0;
      end
   end

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         rb_state_q <= RB_IDLE;
         rb_val_q   <= '0;
      end else begin
         rb_state_q <= rb_state_d;
         rb_val_q   <= rb_val_d;
      end
   end

   assign rb_idle   = (rb_state_q == RB_IDLE);
   assign o_addr    = rb_val_q;
   assign o_addr_oe = (rb_state_q == RB_DRIVE);

   // ---- array, one memory per byte lane
   logic              rd_valid_q;
   logic              rd_valid_d;
   logic              sel_q;
   logic              sel_d;
   logic [DATA_W-1:0] rdata_q;

   always_comb begin
      rd_valid_d = do_read && !i_sys_rst;
      sel_d      = selected && !i_sys_rst;
   end

   // a deselected cycle also turns the read path off
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid_q <= 1'b0;
         sel_q      <= 1'b0;
      end else begin
         rd_valid_q <= rd_valid_d;
         sel_q      <= sel_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < LANE_N; g++) begin : g_lane
         logic [LANE_W-1:0] mem [DEPTH];
         logic [LANE_W-1:0] lane_rd_q;

         // data flops carry no reset; contents are undefined at power-up
         always_ff @(posedge i_clock) begin
            if (do_write && !lane_n[g]) begin
               mem[acc_addr] <= i_data[g*LANE_W +: LANE_W];
            end
            if (do_read && !lane_n[g]) begin
               lane_rd_q <= mem[acc_addr];
            end
         end

         assign rdata_q[g*LANE_W +: LANE_W] = lane_rd_q;

         // drivers follow the enable pin directly, not a clock edge
         assign o_data_oe[g*LANE_W +: LANE_W] =
            {LANE_W{rd_valid_q && !i_output_enable_n && !lane_n[g] && rb_idle}};
      end
   endgenerate

   assign o_data          = rdata_q;
   assign o_port_selected = sel_q;

endmodule

/* sim/mspb_port_monitor.sv */
// checker for one port: lanes, readback timing, wrap flag, reset
// assumes it is bound into the port top module
`timescale 1ns/10ps
module mspb_port_monitor
   import mspb_pkg::*;
#(parameter int DATA_W = DATA_W_DEF) (
   input wire logic              i_clock,
   input wire logic              i_sys_rst,
   input wire logic              i_global_reset_n,
   input wire logic              i_output_enable_n,
   input wire logic              i_lower_byte_select_n,
   input wire logic              i_upper_byte_select_n,
   input wire logic              i_burst_counter_step_n,
   input wire logic              i_counter_readback_n,
   input wire logic              i_wrap_mask_readback_n,
   input wire logic              o_addr_oe,
   input wire logic [DATA_W-1:0] o_data_oe,
   input wire logic              o_counter_wrap_flag_n
);
   default clocking dc @(posedge i_clock); endclocking
   default disable iff (i_sys_rst || !i_global_reset_n);
   // drivers follow enable and lane selects with no clock
   AST_OE: assert property (i_output_enable_n |-> o_data_oe == '0)
      else $error("data on, enable off");
   AST_LOW: assert property (i_lower_byte_select_n |-> o_data_oe[LANE_W-1:0] == '0)
      else $error("lower lane on");
   AST_UP: assert property (
      i_upper_byte_select_n |-> o_data_oe[DATA_W-1:LANE_W] == '0) else $error("upper lane on");
   // readback: one idle cycle, then pins driven and data lines off
   AST_RB_WAIT: assert property (
      $fell(i_counter_readback_n) ##1 !i_counter_readback_n |-> !o_addr_oe ##1 o_addr_oe)
      else $error("readback timing");
   AST_RB_DATA: assert property (o_addr_oe |-> o_data_oe == '0)
      else $error("data on in readback");
   AST_RB_END: assert property (
      o_addr_oe && i_counter_readback_n && i_wrap_mask_readback_n |=> !o_addr_oe)
      else $error("readback stuck");
   // wrap flag: a single low cycle, only after a step
   AST_FLAG_ONE: assert property (!o_counter_wrap_flag_n |=> o_counter_wrap_flag_n)
      else $error("flag too long");
   AST_FLAG_WHY: assert property (
      $fell(o_counter_wrap_flag_n) |-> !$past(i_burst_counter_step_n)) else $error("flag cause");
   // global reset must quiet the port; checked only while the local reset is low
   AST_GRST: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !i_global_reset_n |-> !o_addr_oe && o_counter_wrap_flag_n && o_data_oe == '0)
      else $error("global reset");
   cover property ($fell(o_counter_wrap_flag_n));
   cover property ($rose(o_addr_oe));
   cover property (o_data_oe == '1);
endmodule
bind mspb_port mspb_port_monitor #(.DATA_W(DATA_W)) u_mon (.*);

/* sim/mspb_host_model.sv */
// host side of the address pins
// assumes the device enable is the port's o_addr_oe
`timescale 1ns/10ps
module mspb_host_model
   import mspb_pkg::*;
(
   input  wire logic                  i_clock,
   input  wire logic                  i_host_en,
   input  wire logic [ADDR_W_DEF-1:0] i_host_addr,
   input  wire logic                  i_dev_en,
   input  wire logic [ADDR_W_DEF-1:0] i_dev_addr,
   output logic      [ADDR_W_DEF-1:0] o_pins
);
   logic [ADDR_W_DEF-1:0] last_q;
   // host yields to readback; idle pins invert so stale values never match
   assign o_pins = i_dev_en ? i_dev_addr : i_host_en ? i_host_addr : ~last_q;
   // last level seen on the pins
   always @(posedge i_clock) last_q <= o_pins;
endmodule

/* sim/tb.sv */
// bench for one port: counter table, wrap, lanes, readback, reset
// assumes design, host model and checker are compiled first
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
   $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
   import mspb_pkg::*;
   typedef struct packed {logic [3:0] c; logic [15:0] a; logic [1:0] r; logic [15:0] e;} mspb_row_s;
   // controls {clear, mask, load, step}, readback {count, mask}, expected pins
   mspb_row_s   rows[7] = '{
      '{4'hD, 16'h1234, 2'h1, 16'h1234},
      '{4'hE, 16'h0000, 2'h1, 16'h1235},
      '{4'h9, 16'h00FF, 2'h1, 16'h1235},
      '{4'hC, 16'h4321, 2'h1, 16'h4321},
      '{4'h0, 16'h5555, 2'h1, 16'h0000},
      '{4'hF, 16'h0000, 2'h2, 16'h00FF},
      '{4'hF, 16'h0000, 2'h0, 16'h0000}};
   logic        i_clock = 0, i_sys_rst = 1, i_global_reset_n = 0, i_read_write_n = 1;
   logic        csl = 1, csh = 0, oe_n = 1, lb_n = 1, ub_n = 1, hen = 1;
   logic [3:0]  ctl = 4'hF;
   logic [1:0]  rb = 2'h3;
   logic [15:0] haddr = 16'h0000, bus, o_addr;
   logic [17:0] wdata = 18'h00000, dbus, o_data, o_data_oe;
   logic        o_addr_oe, o_counter_wrap_flag_n, o_port_selected;
   int          err_total = 0, checked = 0;
   mspb_port uut (.*, .i_chip_select_active_low(csl), .i_chip_select_active_high(csh),
      .i_output_enable_n(oe_n), .i_lower_byte_select_n(lb_n), .i_upper_byte_select_n(ub_n),
      .i_burst_counter_clear_n(ctl[3]), .i_wrap_mask_load_n(ctl[2]),
      .i_burst_counter_load_n(ctl[1]), .i_burst_counter_step_n(ctl[0]),
      .i_counter_readback_n(rb[1]), .i_wrap_mask_readback_n(rb[0]), .i_addr(bus),
      .i_data(dbus));
   mspb_host_model host (.i_clock(i_clock), .i_host_en(hen), .i_host_addr(haddr),
      .i_dev_en(o_addr_oe), .i_dev_addr(o_addr), .o_pins(bus));
   // 25 MHz port clock; data pins resolved bit by bit
   always #20 i_clock = ~i_clock;
   assign dbus = (o_data_oe & o_data) | (~o_data_oe & wdata);
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   // readback: host lets go of the pins in the idle cycle, before the port drives;
   // hen drops a cycle in, so back-to-back calls never toggle it in one step
   task automatic rback(input logic [1:0] r, input logic [15:0] e);
      rb = r;
      cyc(1);
      `CHK(o_addr_oe, 1'h0)
      `CHK(o_data_oe, 18'h00000)
      hen = 0;
      cyc(1);
      `CHK(o_addr_oe, 1'h1)
      `CHK(bus, e)
      `CHK(o_data_oe, 18'h00000)
      rb = 2'h3;
      cyc(1);
      `CHK(o_addr_oe, 1'h0)
      hen = 1;
   endtask
   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // main sequence: power-up reset, table, then awkward cases
   initial begin
      cyc(16);
      i_sys_rst = 0;
      i_global_reset_n = 1;
      cyc(3);
      `CHK(o_counter_wrap_flag_n, 1'h1)
      `CHK(o_port_selected, 1'h0)
      rback(2'h2, 16'hFFFF);
      rback(2'h1, 16'h0000);
      $display("reset test done");
      foreach (rows[i]) begin
         ctl = rows[i].c;
         haddr = rows[i].a;
         cyc(1);
         ctl = 4'hF;
         rback(rows[i].r, rows[i].e);
      end
      $display("table test done");
      // wrap of the low byte under mask 00FF; upper bits must hold
      ctl = 4'hD;
      haddr = 16'h12FE;
      cyc(1);
      ctl = 4'hE;
      cyc(2);
      `CHK(o_counter_wrap_flag_n, 1'h0)
      cyc(1);
      `CHK(o_counter_wrap_flag_n, 1'h1)
      ctl = 4'hF;
      rback(2'h1, 16'h1201);
      $display("wrap test done");
      // full write, then upper-only write of zero, then read both lanes
      csl = 0;
      csh = 1;
      i_read_write_n = 0;
      lb_n = 0;
      ub_n = 0;
      haddr = 16'h0010;
      wdata = 18'h3FFFF;
      cyc(1);
      lb_n = 1;
      wdata = 18'h00000;
      cyc(1);
      i_read_write_n = 1;
      lb_n = 0;
      oe_n = 0;
      cyc(1);
      `CHK(o_data, 18'h001FF)
      `CHK(o_data_oe, 18'h3FFFF)
      `CHK(o_port_selected, 1'h1)
      lb_n = 1;
      #1 `CHK(o_data_oe, 18'h3FE00)
      oe_n = 1;
      #1 `CHK(o_data_oe, 18'h00000)
      csh = 0;
      oe_n = 0;
      lb_n = 0;
      cyc(1);
      `CHK(o_data_oe, 18'h00000)
      `CHK(o_port_selected, 1'h0)
      csh = 1;
      rback(2'h1, 16'h1201);
      $display("lane test done");
      // global reset in mid-readback drops the pins at once
      rb = 2'h1;
      cyc(1);
      hen = 0;
      cyc(1);
      `CHK(o_addr_oe, 1'h1)
      i_global_reset_n = 0;
      #1 `CHK(o_addr_oe, 1'h0)
      rb = 2'h3;
      cyc(1);
      i_global_reset_n = 1;
      hen = 1;
      cyc(3);
      rback(2'h1, 16'h0000);
      rback(2'h2, 16'hFFFF);
      $display("global reset test done");
      // local reset outranks a counter load in the same cycle, and drops
      // the read path of a port that is still selected
      ctl = 4'hB;
      haddr = 16'h0F0F;
      cyc(1);
      ctl = 4'hD;
      haddr = 16'h1357;
      i_sys_rst = 1;
      cyc(1);
      `CHK(o_port_selected, 1'h0)
      `CHK(o_data_oe, 18'h00000)
      ctl = 4'hF;
      i_sys_rst = 0;
      cyc(1);
      rback(2'h1, 16'h0000);
      rback(2'h2, 16'hFFFF);
      $display("local reset test done");
      finish_test;
   end
   // tests need about 90 cycles; a wide margin catches a hang
   initial begin
      repeat (3000) @(posedge i_clock);
      err_total++;
      finish_test;
   end
endmodule
